// ==== hw/pmdr_params.svh ====
`ifndef PMDR_PARAMS_SVH
`define PMDR_PARAMS_SVH
`define PMDR_ADDR_W 2
`define PMDR_CCU_OFS 2'h0
`define PMDR_MISC_OFS 2'h1
`define PMDR_AUX_OFS 2'h2
`define PMDR_CCU_MASK 16'h0707
`define PMDR_MISC_MASK 16'h0782
`define PMDR_AUX_MASK 16'h000E
`define PMDR_RST_VAL 16'h0000
`define PMDR_CAP1_BIT 8
`define PMDR_CAP2_BIT 9
`define PMDR_CAP3_BIT 10
`define PMDR_CMP1_BIT 0
`define PMDR_CMP2_BIT 1
`define PMDR_CMP3_BIT 2
`define PMDR_CMPG_BIT 10
`define PMDR_CAL_BIT 9
`define PMDR_PAR_BIT 8
`define PMDR_CRC_BIT 7
`define PMDR_TWI2_BIT 1
`define PMDR_REFO_BIT 3
`define PMDR_CTU_BIT 2
`define PMDR_VDET_BIT 1
`endif

// ==== hw/pmdr_pkg.sv ====
package pmdr_pkg;
   typedef struct packed {
      logic capture_three_off;
      logic capture_two_off;
      logic capture_one_off;
      logic compare_three_off;
      logic compare_two_off;
      logic compare_one_off;
      logic comparator_group_off;
      logic calendar_clock_off;
      logic parallel_port_off;
      logic checksum_unit_off;
      logic second_two_wire_off;
      logic ref_clock_out_off;
      logic charge_time_unit_off;
      logic voltage_detect_off;
   } pmdr_gate_t;
endpackage

// ==== hw/pmdr_reg16.sv ====
`timescale 1ns/1ps
`include "pmdr_params.svh"
// one disable register; only bits set in the mask hold storage
module pmdr_reg16 #(
   parameter logic [15:0] MASK = 16'h0000
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic wr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] value_out
);
   logic [15:0] value_r;
   logic [15:0] value_nxt;
   assign value_nxt = wr_in ? (wdata_in & MASK) : value_r; // [RULE9]
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         value_r <= `PMDR_RST_VAL; // [RULE8]
      end else begin
         value_r <= value_nxt;
      end
   end
   assign value_out = value_r;
endmodule

// ==== hw/pmdr_top.sv ====
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pmdr_params.svh"
// Contract
// RULE1: register 0 bits 10,9,8 disable capture units 3,2,1 and bits 2,1,0 disable compare units 3,2,1.
// RULE2: register 1 bits 10,9,8,7,1 disable comparators, calendar clock, parallel port, checksum, second two-wire.
// RULE3: register 2 bit 3 disables the reference clock output when set and powers it when clear.
// RULE4: register 2 bit 2 disables the charge-time unit when set and powers it when clear.
// RULE5: register 2 bit 1 disables the voltage detector when set and powers it when clear.
// RULE6: each disable bit at 1 holds its peripheral off, at 0 supplies its power and clock.
// RULE7: unimplemented bit positions read as zero.
// RULE8: implemented bits are read/write and clear to 0 at reset.
// RULE9: writes to unimplemented bits are ignored and stored bits drive the gating controls directly.
module pmdr_top (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [`PMDR_ADDR_W-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output pmdr_pkg::pmdr_gate_t gate_out
);
   import pmdr_pkg::*;

   // shared by the write enables, the read mux and the checks below
   function automatic logic pmdr_hit(input logic [`PMDR_ADDR_W-1:0] addr, input logic [`PMDR_ADDR_W-1:0] ofs);
      return (addr == ofs);
   endfunction

   logic [15:0] ccu_q;
   logic [15:0] misc_q;
   logic [15:0] aux_q;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   wire logic sel_ccu;
   wire logic sel_misc;
   wire logic sel_aux;
   wire logic sel_none;

   assign sel_ccu = pmdr_hit(addr_in, `PMDR_CCU_OFS);
   assign sel_misc = pmdr_hit(addr_in, `PMDR_MISC_OFS);
   assign sel_aux = pmdr_hit(addr_in, `PMDR_AUX_OFS);
   // index 3 holds nothing: writes there vanish and reads give zero
   assign sel_none = !(sel_ccu || sel_misc || sel_aux);

   pmdr_reg16 #(.MASK(`PMDR_CCU_MASK)) u_ccu (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .wr_in(wr_in & sel_ccu),
      .wdata_in(wdata_in),
      .value_out(ccu_q)
   );
   pmdr_reg16 #(.MASK(`PMDR_MISC_MASK)) u_misc (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .wr_in(wr_in & sel_misc),
      .wdata_in(wdata_in),
      .value_out(misc_q)
   );
   pmdr_reg16 #(.MASK(`PMDR_AUX_MASK)) u_aux (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .wr_in(wr_in & sel_aux),
      .wdata_in(wdata_in),
      .value_out(aux_q)
   );

   // unmapped address reads zero; stored masks already keep reserved bits clear
   assign rdata_nxt = !rd_in ? 16'h0000 :
                      sel_ccu ? ccu_q :
                      sel_misc ? misc_q :
                      sel_aux ? aux_q : 16'h0000; // [RULE7]

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rdata_r <= `PMDR_RST_VAL;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata_out = rdata_r;

   // gates come straight from the storage flops, no extra stage
   // one driver for the whole struct keeps the output a single net for lint
   assign gate_out = '{
      capture_three_off: ccu_q[`PMDR_CAP3_BIT], // [RULE1] [RULE6] [RULE9]
      capture_two_off: ccu_q[`PMDR_CAP2_BIT], // [RULE1]
      capture_one_off: ccu_q[`PMDR_CAP1_BIT], // [RULE1]
      compare_three_off: ccu_q[`PMDR_CMP3_BIT], // [RULE1]
      compare_two_off: ccu_q[`PMDR_CMP2_BIT], // [RULE1]
      compare_one_off: ccu_q[`PMDR_CMP1_BIT], // [RULE1]
      comparator_group_off: misc_q[`PMDR_CMPG_BIT], // [RULE2]
      calendar_clock_off: misc_q[`PMDR_CAL_BIT], // [RULE2]
      parallel_port_off: misc_q[`PMDR_PAR_BIT], // [RULE2]
      checksum_unit_off: misc_q[`PMDR_CRC_BIT], // [RULE2]
      second_two_wire_off: misc_q[`PMDR_TWI2_BIT], // [RULE2]
      ref_clock_out_off: aux_q[`PMDR_REFO_BIT], // [RULE3]
      charge_time_unit_off: aux_q[`PMDR_CTU_BIT], // [RULE4]
      voltage_detect_off: aux_q[`PMDR_VDET_BIT] // [RULE5]
   };

   property p_ccu_write;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_ccu) |=> (ccu_q == ($past(wdata_in) & `PMDR_CCU_MASK));
   endproperty
   a_ccu_write: assert property (p_ccu_write) else $error("capture/compare write wrong"); // [RULE1]

   property p_misc_write;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_misc) |=> (misc_q == ($past(wdata_in) & `PMDR_MISC_MASK));
   endproperty
   a_misc_write: assert property (p_misc_write) else $error("misc write wrong"); // [RULE2]

   property p_refo;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_aux) |=> (gate_out.ref_clock_out_off == $past(wdata_in[`PMDR_REFO_BIT]));
   endproperty
   a_refo: assert property (p_refo) else $error("ref clock gate wrong"); // [RULE3]

   property p_ctu;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_aux) |=> (gate_out.charge_time_unit_off == $past(wdata_in[`PMDR_CTU_BIT]));
   endproperty
   a_ctu: assert property (p_ctu) else $error("charge time gate wrong"); // [RULE4]

   property p_vdet;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_aux) |=> (gate_out.voltage_detect_off == $past(wdata_in[`PMDR_VDET_BIT]));
   endproperty
   a_vdet: assert property (p_vdet) else $error("voltage detect gate wrong"); // [RULE5]

   property p_hold;
      @(posedge clock_in) disable iff (!rst_n_in)
      // an edge that samples reset low clears the gates, so it is no hold cycle
      (rst_n_in && !wr_in) |=> $stable(gate_out);
   endproperty
   a_hold: assert property (p_hold) else $error("gate changed without write"); // [RULE6]

   property p_read_zero;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rd_in && sel_aux) |=> (rdata_out[15:4] == 12'h000 && rdata_out[0] == 1'b0);
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("reserved bits read nonzero"); // [RULE7]

   property p_readback;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_misc) ##1 (rd_in && sel_misc && !wr_in) |=> (rdata_out == ($past(wdata_in, 2) & `PMDR_MISC_MASK));
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch"); // [RULE8]

   property p_reset;
      @(posedge clock_in) !rst_n_in |=> (ccu_q == 16'h0000 && misc_q == 16'h0000 && aux_q == 16'h0000);
   endproperty
   a_reset: assert property (p_reset) else $error("registers not cleared by reset"); // [RULE8]

   property p_mask;
      @(posedge clock_in) disable iff (!rst_n_in)
      (ccu_q & ~`PMDR_CCU_MASK) == 16'h0000 && (misc_q & ~`PMDR_MISC_MASK) == 16'h0000 &&
         (aux_q & ~`PMDR_AUX_MASK) == 16'h0000;
   endproperty
   a_mask: assert property (p_mask) else $error("reserved bit stored"); // [RULE9]

   c_ccu_wr: cover property (@(posedge clock_in) disable iff (!rst_n_in) wr_in && sel_ccu);
   c_aux_rd: cover property (@(posedge clock_in) disable iff (!rst_n_in) rd_in && sel_aux);
   c_wr_rd: cover property (@(posedge clock_in) disable iff (!rst_n_in) (wr_in && sel_misc) ##1 (rd_in && sel_misc));
   c_aux_wr_rd: cover property (@(posedge clock_in) disable iff (!rst_n_in) (wr_in && sel_aux) ##1 (rd_in && sel_aux));
   c_unmapped: cover property (@(posedge clock_in) disable iff (!rst_n_in) wr_in && sel_none);

   property p_cap_gate;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_ccu) |=> ({gate_out.capture_three_off, gate_out.capture_two_off, gate_out.capture_one_off}
         == $past(wdata_in[`PMDR_CAP3_BIT:`PMDR_CAP1_BIT]));
   endproperty
   a_cap_gate: assert property (p_cap_gate) else $error("capture gates wrong"); // [RULE1]

   property p_cmp_gate;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_ccu) |=> ({gate_out.compare_three_off, gate_out.compare_two_off, gate_out.compare_one_off}
         == $past(wdata_in[`PMDR_CMP3_BIT:`PMDR_CMP1_BIT]));
   endproperty
   a_cmp_gate: assert property (p_cmp_gate) else $error("compare gates wrong"); // [RULE1]

   property p_misc_gate;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_misc) |=> ({gate_out.comparator_group_off, gate_out.calendar_clock_off, gate_out.parallel_port_off,
         gate_out.checksum_unit_off, gate_out.second_two_wire_off}
         == {$past(wdata_in[`PMDR_CMPG_BIT:`PMDR_CRC_BIT]), $past(wdata_in[`PMDR_TWI2_BIT])});
   endproperty
   a_misc_gate: assert property (p_misc_gate) else $error("misc gates wrong"); // [RULE2]

   property p_ccu_read_zero;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rd_in && sel_ccu) |=> (rdata_out[15:11] == 5'h00 && rdata_out[7:3] == 5'h00);
   endproperty
   a_ccu_read_zero: assert property (p_ccu_read_zero) else $error("capture/compare reserved bits nonzero"); // [RULE7]

   property p_misc_read_zero;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rd_in && sel_misc) |=> (rdata_out[15:11] == 5'h00 && rdata_out[6:2] == 5'h00 && rdata_out[0] == 1'b0);
   endproperty
   a_misc_read_zero: assert property (p_misc_read_zero) else $error("misc reserved bits nonzero"); // [RULE7]

   property p_unmapped_read;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rd_in && sel_none) |=> (rdata_out == 16'h0000);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped index read nonzero"); // [RULE7]

   property p_aux_readback;
      @(posedge clock_in) disable iff (!rst_n_in)
      (wr_in && sel_aux) ##1 (rd_in && sel_aux && !wr_in) |=> (rdata_out == ($past(wdata_in, 2) & `PMDR_AUX_MASK));
   endproperty
   a_aux_readback: assert property (p_aux_readback) else $error("aux readback mismatch"); // [RULE8]

   // outputs too, not only the storage, must be clear after a reset edge
   property p_reset_out;
      @(posedge clock_in) !rst_n_in |=> (gate_out == 14'h0000 && rdata_out == 16'h0000);
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset"); // [RULE8]

   property p_ccu_keep;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rst_n_in && wr_in && !sel_ccu) |=> $stable(ccu_q);
   endproperty
   a_ccu_keep: assert property (p_ccu_keep) else $error("capture/compare changed by other write"); // [RULE9]

   property p_misc_keep;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rst_n_in && wr_in && !sel_misc) |=> $stable(misc_q);
   endproperty
   a_misc_keep: assert property (p_misc_keep) else $error("misc changed by other write"); // [RULE9]

   property p_aux_keep;
      @(posedge clock_in) disable iff (!rst_n_in)
      (rst_n_in && wr_in && !sel_aux) |=> $stable(aux_q);
   endproperty
   a_aux_keep: assert property (p_aux_keep) else $error("aux changed by other write"); // [RULE9]
endmodule

// ==== verif/test_pmdr_top.sv ====
`timescale 1ns/1ps
`include "pmdr_params.svh"
module test_pmdr_top;
   import pmdr_pkg::*;
   typedef struct packed {
      logic [1:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } pmdr_row_t;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] addr_in = 2'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] rdata_out;
   pmdr_gate_t gate_out;
   logic [15:0] m [0:3] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] msk [0:3] = '{`PMDR_CCU_MASK, `PMDR_MISC_MASK, `PMDR_AUX_MASK, 16'h0000};
   int err_count = 0;
   int check_count = 0;
   // set every bit, then clear or mix; address 3 must stay silent
   pmdr_row_t rows [0:7] = '{'{2'h0, 16'hFFFF, 16'h0707}, '{2'h1, 16'hFFFF, 16'h0782},
      '{2'h2, 16'hFFFF, 16'h000E}, '{2'h3, 16'hFFFF, 16'h0000}, '{2'h0, 16'hF8F8, 16'h0000},
      '{2'h1, 16'h5A5A, 16'h0202}, '{2'h2, 16'h0004, 16'h0004}, '{2'h1, 16'hA5A5, 16'h0580}};
   pmdr_top u_pmdr_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gate_out(gate_out));
   initial forever #5 clock_in = ~clock_in;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // gate bits in struct order, built from the bench's own copy of the registers
   function automatic logic [15:0] gate_exp();
      return {2'h0, m[0][10:8], m[0][2:0], m[1][10:7], m[1][1], m[2][3:1]};
   endfunction
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      m[a] = d & msk[a];
      #1 chk({2'h0, gate_out}, gate_exp());
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
      @(posedge clock_in);
      #1 chk(rdata_out, 16'h0000);
   endtask
   // write, then read the same register in the very next cycle
   task automatic wr_rd(input logic [1:0] a, input logic [15:0] d, input logic [15:0] e);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      m[a] = d & msk[a];
      #1 chk(rdata_out, e);
      chk({2'h0, gate_out}, gate_exp());
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 4; i++) rd(2'(i), 16'h0000);
      chk({2'h0, gate_out}, 16'h0000);
      $display("test reset values done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      $display("test row table done");
      // read in the cycle right after the write must see the new value
      wr_rd(2'h2, 16'hFFF7, 16'h0006);
      wr_rd(2'h1, 16'h0F0F, 16'h0702);
      wr_rd(2'h0, 16'h0402, 16'h0402);
      $display("test back to back done");
      wr(2'h0, 16'hFFFF);
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      @(posedge clock_in);
      rst_n_in <= 1'b1;
      m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      #1 chk({2'h0, gate_out}, 16'h0000);
      rd(2'h0, 16'h0000);
      $display("test mid-run reset done");
      end_of_test();
   end
   // about 71 cycles (some 706 ns) are needed; this span is about seventy times that
   initial begin
      #50000;
      err_count++;
      end_of_test();
   end
endmodule
